// ===== moc_config.sv
`timescale 1ns/1ps
`include "moc_defines.svh"
module moc_config #(
    parameter int DB_CYC = `MOC_DEBOUNCE_CYC
) (
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    input  wire logic [7:0]  reg_addr,
    input  wire logic [7:0]  reg_wdata,
    output logic      [7:0]  reg_rdata,
    output logic             reg_rvalid,
    input  wire logic        oem_pw_valid,
    input  wire logic        tx_fault_raw,
    input  wire logic        transmit_off_input,
    input  wire logic        pin7_is_laser_shutdown_output,
    input  wire logic        laser_on,
    input  wire logic [7:0]  temp_sensed,
    input  wire logic [7:0]  temp_case,
    output logic             transmit_fault_output,
    output logic             laser_shutdown_output,
    output logic      [12:0] laser_start_current_level,
    output logic             cap_precharge,
    output logic      [7:0]  lut_index_temp,
    output logic      [7:0]  temp_result,
    output logic             multipart_mode,
    output logic      [7:0]  pw_base_addr,
    output logic             bus_timeout_en,
    output logic             dac_clear
);
    logic [7:0] cfg5;
    logic [7:0] cfg6;
    logic [7:0] start;
    logic [7:0] nv_rdata;
    logic       nv_wr;
    logic [1:0] nv_sel;
    logic       hit;
    logic       rd_pend;
    logic       txoff_db;
    logic       txoff_prev;
    logic       flt_latch;
    logic       fault_q;
    logic       fault_prev;
    logic       fault_now;

    logic        next_rd_pend;
    logic [7:0]  next_reg_rdata;
    logic        next_reg_rvalid;
    logic        next_txoff_prev;
    logic        next_flt_latch;
    logic        next_fault_prev;
    logic        next_fault_out;
    logic        next_laser_shutdown_output;
    logic [12:0] next_start_lvl;
    logic        next_precharge;
    logic [7:0]  next_lut_temp;
    logic [7:0]  next_temp_res;
    logic        next_multi;
    logic [7:0]  next_pw_base;
    logic        next_tmo_en;
    logic        next_dac_clear;

    // map an address to a store slot
    function automatic logic [1:0] moc_slot(input logic [7:0] a);
        if (a == `MOC_ADDR_START)
            moc_slot = 2'd0;
        else if (a == `MOC_ADDR_CFG5)
            moc_slot = 2'd1;
        else
            moc_slot = 2'd2;
    endfunction : moc_slot

    // ************************************************************
    // register access
    // ************************************************************
    assign hit    = (reg_addr == `MOC_ADDR_START) || (reg_addr == `MOC_ADDR_CFG5) ||
                    (reg_addr == `MOC_ADDR_CFG6);
    assign nv_sel = moc_slot(reg_addr);
    assign nv_wr  = reg_wr && hit && oem_pw_valid;

    moc_nv_store u_store (
        .clk     (clk),
        .wr_en   (nv_wr),
        .wr_sel  (nv_sel),
        .wr_data ((nv_sel == 2'd0) ? (reg_wdata & `MOC_START_MASK) :
                  (nv_sel == 2'd2) ? (reg_wdata & `MOC_CFG6_MASK) : reg_wdata),
        .rd_sel  (nv_sel),
        .rd_data (nv_rdata),
        .cfg5    (cfg5),
        .cfg6    (cfg6),
        .start   (start)
    );

    moc_debounce #(.DB_CYC(DB_CYC)) u_db (
        .clk    (clk),
        .rst_n  (rst_n),
        .enable (cfg6[`MOC_C6_DEBOUNCE]),
        .din    (transmit_off_input),
        .dout   (txoff_db)
    );

    // read answers one cycle after the store registers its data
    always_comb begin
        next_rd_pend    = reg_rd && hit && oem_pw_valid;
        next_reg_rvalid = rd_pend;
        next_reg_rdata  = rd_pend ? nv_rdata : `MOC_RESET_BYTE;
    end

    // ************************************************************
    // fault and laser control
    // ************************************************************
    // latch clears on any debounced edge of transmit-off; a new fault wins
    always_comb begin
        next_txoff_prev = txoff_db;
        next_fault_prev = tx_fault_raw;
        next_flt_latch  = flt_latch;
        if (txoff_db != txoff_prev)
            next_flt_latch = 1'b0;
        if (tx_fault_raw)
            next_flt_latch = 1'b1;
        fault_now      = cfg6[`MOC_C6_FLT_FOLLOW] ? tx_fault_raw : next_flt_latch;
        next_fault_out = fault_now ^ cfg5[`MOC_C5_FLT_POL];
        // shutdown sees the same fault view as the fault pin, so follow mode releases it
        next_laser_shutdown_output      = pin7_is_laser_shutdown_output && !cfg5[`MOC_C5_LASER_SHUTDOWN_OUTPUT_OFF] && fault_now;
        // 13 bits: the top code gives 5625 uA, which would wrap in 12
        next_start_lvl = 13'(start[3:0]) * `MOC_STEP_UA;
        next_precharge = fault_prev && !tx_fault_raw && (start[3:0] != 4'h0);
        next_lut_temp  = cfg5[`MOC_C5_LUT_COMP] ? temp_case : temp_sensed;
        next_temp_res  = cfg5[`MOC_C5_TEMP_COMP] ? temp_case : temp_sensed;
        next_multi     = cfg5[`MOC_C5_MULTI];
        next_pw_base   = cfg5[`MOC_C5_PW_LOC] ? `MOC_PW_HIGH : `MOC_PW_LOW;
        next_tmo_en    = !cfg5[`MOC_C5_TMO_OFF];
        next_dac_clear = !laser_on && !cfg5[`MOC_C5_DAC_KEEP];
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            rd_pend                   <= 1'b0;
            reg_rdata                 <= `MOC_RESET_BYTE;
            reg_rvalid                <= 1'b0;
            txoff_prev                <= 1'b0;
            flt_latch                 <= 1'b0;
            fault_prev                <= 1'b0;
            transmit_fault_output     <= 1'b0;
            laser_shutdown_output     <= 1'b0;
            laser_start_current_level <= '0;
            cap_precharge             <= 1'b0;
            lut_index_temp            <= '0;
            temp_result               <= '0;
            multipart_mode            <= 1'b0;
            pw_base_addr              <= `MOC_PW_LOW;
            bus_timeout_en            <= 1'b1;
            dac_clear                 <= 1'b0;
        end else begin
            rd_pend                   <= next_rd_pend;
            reg_rdata                 <= next_reg_rdata;
            reg_rvalid                <= next_reg_rvalid;
            txoff_prev                <= next_txoff_prev;
            flt_latch                 <= next_flt_latch;
            fault_prev                <= next_fault_prev;
            transmit_fault_output     <= next_fault_out;
            laser_shutdown_output     <= next_laser_shutdown_output;
            laser_start_current_level <= next_start_lvl;
            cap_precharge             <= next_precharge;
            lut_index_temp            <= next_lut_temp;
            temp_result               <= next_temp_res;
            multipart_mode            <= next_multi;
            pw_base_addr              <= next_pw_base;
            bus_timeout_en            <= next_tmo_en;
            dac_clear                 <= next_dac_clear;
        end
    end

    // ************************************************************
    // checks
    // ************************************************************
    AST_NO_PW_NO_WRITE: assert property (@(posedge clk) disable iff (!rst_n)
        (reg_wr && !oem_pw_valid) |=> ($stable(cfg5) && $stable(cfg6) && $stable(start)))
        else $error("write without password reached store");
    AST_NO_PW_NO_READ: assert property (@(posedge clk) disable iff (!rst_n)
        (reg_rd && !oem_pw_valid) |=> ##1 !reg_rvalid)
        else $error("read answered without password");
    AST_START_LVL: assert property (@(posedge clk) disable iff (!rst_n)
        (start[3:0] == 4'h0) |=> (laser_start_current_level == 13'd0))
        else $error("start current nonzero for code zero");
    AST_POLARITY: assert property (@(posedge clk) disable iff (!rst_n)
        (cfg6[`MOC_C6_FLT_FOLLOW] && tx_fault_raw) |=>
        (transmit_fault_output == !$past(cfg5[`MOC_C5_FLT_POL])))
        else $error("fault polarity wrong");
    AST_LASER_SHUTDOWN_OUTPUT_MASK: assert property (@(posedge clk) disable iff (!rst_n)
        cfg5[`MOC_C5_LASER_SHUTDOWN_OUTPUT_OFF] |=> !laser_shutdown_output)
        else $error("shutdown asserted while disabled");
    AST_LUT_SEL: assert property (@(posedge clk) disable iff (!rst_n)
        cfg5[`MOC_C5_LUT_COMP] |=> (lut_index_temp == $past(temp_case)))
        else $error("lut index temperature wrong");
    AST_TEMP_SEL: assert property (@(posedge clk) disable iff (!rst_n)
        !cfg5[`MOC_C5_TEMP_COMP] |=> (temp_result == $past(temp_sensed)))
        else $error("temperature result source wrong");
    AST_PW_LOC: assert property (@(posedge clk) disable iff (!rst_n)
        cfg5[`MOC_C5_PW_LOC] |=> (pw_base_addr == `MOC_PW_HIGH))
        else $error("password base wrong");
    AST_TIMEOUT: assert property (@(posedge clk) disable iff (!rst_n)
        cfg5[`MOC_C5_TMO_OFF] |=> !bus_timeout_en)
        else $error("timeout enabled while disabled");
    AST_DAC: assert property (@(posedge clk) disable iff (!rst_n)
        (!laser_on && !cfg5[`MOC_C5_DAC_KEEP]) |=> dac_clear)
        else $error("dacs not cleared with laser off");
    AST_LATCH_HOLD: assert property (@(posedge clk) disable iff (!rst_n)
        (flt_latch && txoff_db == txoff_prev) |=> flt_latch)
        else $error("fault latch dropped without toggle");
    AST_MULTI: assert property (@(posedge clk) disable iff (!rst_n)
        cfg5[`MOC_C5_MULTI] |=> multipart_mode)
        else $error("multipart mode not on");
    // latch: a raw fault sets it, an edge with no fault clears it
    AST_SET_WINS: assert property (@(posedge clk) disable iff (!rst_n)
        tx_fault_raw |=> flt_latch)
        else $error("fault latch not set by raw fault");
    AST_LATCH_CLEAR: assert property (@(posedge clk) disable iff (!rst_n)
        (!tx_fault_raw && txoff_db != txoff_prev) |=> !flt_latch)
        else $error("fault latch kept after transmit-off edge");
    // shutdown gating, only when the pin is the shutdown output
    AST_LASER_SHUTDOWN_OUTPUT_DRIVE: assert property (@(posedge clk) disable iff (!rst_n)
        (pin7_is_laser_shutdown_output && !cfg5[`MOC_C5_LASER_SHUTDOWN_OUTPUT_OFF] && fault_now) |=>
        laser_shutdown_output)
        else $error("fault did not drive shutdown");
    AST_LASER_SHUTDOWN_OUTPUT_PIN: assert property (@(posedge clk) disable iff (!rst_n)
        !pin7_is_laser_shutdown_output |=> !laser_shutdown_output)
        else $error("shutdown driven while pin not shutdown");
    // precharge only on fault release with a nonzero start code
    AST_PRECHARGE: assert property (@(posedge clk) disable iff (!rst_n)
        ($fell(tx_fault_raw) && start[3:0] != 4'h0) |=> cap_precharge)
        else $error("no precharge after fault release");
    AST_NO_PRECHARGE: assert property (@(posedge clk) disable iff (!rst_n)
        (start[3:0] == 4'h0) |=> !cap_precharge)
        else $error("precharge with zero start code");
    AST_RD_ANSWER: assert property (@(posedge clk) disable iff (!rst_n)
        (reg_rd && hit && oem_pw_valid) |=> ##1 reg_rvalid)
        else $error("accepted read not answered");
    // the store only moves on an accepted write
    AST_STORE_KEEP: assert property (@(posedge clk) disable iff (!rst_n)
        !nv_wr |=> ($stable(cfg5) && $stable(cfg6) && $stable(start)))
        else $error("stored byte changed without write");
    COV_WRITE: cover property (@(posedge clk) disable iff (!rst_n) nv_wr);
    COV_READ: cover property (@(posedge clk) disable iff (!rst_n) reg_rvalid);
    COV_LASER_SHUTDOWN_OUTPUT: cover property (@(posedge clk) disable iff (!rst_n) laser_shutdown_output);
    COV_PRE: cover property (@(posedge clk) disable iff (!rst_n) cap_precharge);
    COV_FOLLOW: cover property (@(posedge clk) disable iff (!rst_n)
        cfg6[`MOC_C6_FLT_FOLLOW] && tx_fault_raw);
endmodule : moc_config

// ===== moc_defines.svh
`ifndef MOC_DEFINES_SVH
`define MOC_DEFINES_SVH
// ************************************************************
// register map
// ************************************************************
`define MOC_ADDR_START      8'h19
`define MOC_ADDR_CFG5       8'h1a
`define MOC_ADDR_CFG6       8'h1b
`define MOC_RESET_BYTE      8'h00
`define MOC_CFG6_MASK       8'h1f
`define MOC_START_MASK      8'h0f
// ************************************************************
// config five fields
// ************************************************************
`define MOC_C5_LASER_SHUTDOWN_OUTPUT_OFF     7
`define MOC_C5_LUT_COMP     6
`define MOC_C5_TEMP_COMP    5
`define MOC_C5_FLT_POL      4
`define MOC_C5_MULTI        3
`define MOC_C5_PW_LOC       2
`define MOC_C5_TMO_OFF      1
`define MOC_C5_DAC_KEEP     0
// ************************************************************
// config six fields
// ************************************************************
`define MOC_C6_DEBOUNCE     4
`define MOC_C6_FLT_FOLLOW   0
// ************************************************************
// constants and timing
// ************************************************************
`define MOC_PW_LOW          8'h78
`define MOC_PW_HIGH         8'h7b
`define MOC_STEP_UA         13'd375
`define MOC_CLK_MHZ         200
`define MOC_DEBOUNCE_MS     5
`define MOC_DEBOUNCE_CYC    (`MOC_DEBOUNCE_MS * 1000 * 1000 * `MOC_CLK_MHZ / 1000)
`endif

// ===== moc_pkg.sv
package moc_pkg;
    // debounce filter states
    typedef enum logic [1:0] {
        MOC_DB_STABLE,
        MOC_DB_CHANGING
    } moc_db_state_t;
endpackage : moc_pkg

// ===== moc_nv_store.sv
`timescale 1ns/1ps
`include "moc_defines.svh"
// non-volatile byte store: rst_n does not touch the contents
module moc_nv_store (
    input  wire logic       clk,
    input  wire logic       wr_en,
    input  wire logic [1:0] wr_sel,
    input  wire logic [7:0] wr_data,
    input  wire logic [1:0] rd_sel,
    output logic      [7:0] rd_data,
    output logic      [7:0] cfg5,
    output logic      [7:0] cfg6,
    output logic      [7:0] start
);
    logic [7:0] mem [0:3];
    logic [7:0] next_rd_data;
    logic       pwr_up_done = 1'b0;

    // ************************************************************
    // storage
    // ************************************************************
    // only initial power-up loads defaults; later resets keep contents
    always_comb begin
        next_rd_data = mem[rd_sel];
    end

    always_ff @(posedge clk) begin
        if (!pwr_up_done) begin
            mem[0] <= `MOC_RESET_BYTE;
            mem[1] <= `MOC_RESET_BYTE;
            mem[2] <= `MOC_RESET_BYTE;
            mem[3] <= `MOC_RESET_BYTE;
            pwr_up_done <= 1'b1;
        end else if (wr_en) begin
            mem[wr_sel] <= wr_data;
        end
        rd_data <= next_rd_data;
    end

    assign cfg5  = mem[1];
    assign cfg6  = mem[2];
    assign start = mem[0];
endmodule : moc_nv_store

// ===== moc_debounce.sv
`timescale 1ns/1ps
`include "moc_defines.svh"
// glitch filter for transmit-off; bypassed when disabled
module moc_debounce #(
    parameter int DB_CYC = `MOC_DEBOUNCE_CYC
) (
    input  wire logic clk,
    input  wire logic rst_n,
    input  wire logic enable,
    input  wire logic din,
    output logic      dout
);
    moc_pkg::moc_db_state_t state;
    moc_pkg::moc_db_state_t next_state;
    logic [20:0]            cnt;
    logic [20:0]            next_cnt;
    logic                   next_dout;

    // ************************************************************
    // filter
    // ************************************************************
    always_comb begin
        next_state = state;
        next_cnt   = cnt;
        next_dout  = dout;
        if (!enable) begin
            next_state = moc_pkg::MOC_DB_STABLE;
            next_cnt   = '0;
            next_dout  = din;
        end else begin
            unique case (state)
                moc_pkg::MOC_DB_STABLE: begin
                    if (din != dout) begin
                        next_state = moc_pkg::MOC_DB_CHANGING;
                        next_cnt   = 21'd1;
                    end
                end
                moc_pkg::MOC_DB_CHANGING: begin
                    if (din == dout) begin
                        next_state = moc_pkg::MOC_DB_STABLE; // glitch rejected
                    end else if (cnt >= 21'(DB_CYC)) begin
                        next_dout  = din;
                        next_state = moc_pkg::MOC_DB_STABLE;
                    end else begin
                        next_cnt = cnt + 21'd1;
                    end
                end
                default: next_state = moc_pkg::MOC_DB_STABLE;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state <= moc_pkg::MOC_DB_STABLE;
            cnt   <= '0;
            dout  <= 1'b0;
        end else begin
            state <= next_state;
            cnt   <= next_cnt;
            dout  <= next_dout;
        end
    end
endmodule : moc_debounce

// ===== moc_host_model.sv
`timescale 1ns/1ps
// ********************************
// host side of the register access
// ********************************
module moc_host_model (
    input  wire logic       clk,
    output logic            reg_wr,
    output logic            reg_rd,
    output logic      [7:0] reg_addr,
    output logic      [7:0] reg_wdata,
    output logic            oem_pw_valid,
    input  wire logic [7:0] reg_rdata,
    input  wire logic       reg_rvalid
);
    // idle bus at time zero, no password yet
    initial begin
        reg_wr       = 1'b0;
        reg_rd       = 1'b0;
        reg_addr     = 8'h00;
        reg_wdata    = 8'h00;
        oem_pw_valid = 1'b0;
    end

    // password is entered after a first read and write have been tried without it
    task automatic set_pw(input logic v);
        @(negedge clk);
        oem_pw_valid = v;
    endtask : set_pw

    // one write pulse; released lines show the inverse, not the old value
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        reg_addr  = a;
        reg_wdata = d;
        reg_wr    = 1'b1;
        @(negedge clk);
        reg_wr    = 1'b0;
        reg_addr  = ~a;
        reg_wdata = ~d;
    endtask : wr

    // one read pulse, then a bounded wait for the data strobe
    task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic got);
        d   = 8'h00;
        got = 1'b0;
        @(negedge clk);
        reg_addr = a;
        reg_rd   = 1'b1;
        @(negedge clk);
        reg_rd   = 1'b0;
        reg_addr = ~a;
        for (int i = 0; i < 5; i++) begin
            @(negedge clk);
            if (!got && reg_rvalid === 1'b1) begin
                got = 1'b1;
                d   = reg_rdata;
            end
        end
    endtask : rd
endmodule : moc_host_model

// ===== tb.sv
`timescale 1ns/1ps
module tb;
    logic        clk;
    logic        rst_n;
    logic        reg_wr;
    logic        reg_rd;
    logic [7:0]  reg_addr;
    logic [7:0]  reg_wdata;
    logic [7:0]  reg_rdata;
    logic        reg_rvalid;
    logic        oem_pw_valid;
    logic        tx_fault_raw;
    logic        transmit_off_input;
    logic        pin7_is_laser_shutdown_output;
    logic        laser_on;
    logic [7:0]  temp_sensed;
    logic [7:0]  temp_case;
    logic        transmit_fault_output;
    logic        laser_shutdown_output;
    logic [12:0] laser_start_current_level;
    logic        cap_precharge;
    logic [7:0]  lut_index_temp;
    logic [7:0]  temp_result;
    logic        multipart_mode;
    logic [7:0]  pw_base_addr;
    logic        bus_timeout_en;
    logic        dac_clear;
    int          pre_count = 0;
    int          pre_base;
    int          fail_count;
    int          n_tests;
    logic [7:0]  cfg_vals [4] = '{8'h00, 8'hff, 8'h5a, 8'ha5};

    // ****************************
    // clock, design and host model
    // ****************************
    always #2.5 clk = ~clk;

    moc_config #(.DB_CYC(8)) moc_config_inst (.*);

    moc_host_model moc_host_model_inst (
        .clk          (clk),
        .reg_wr       (reg_wr),
        .reg_rd       (reg_rd),
        .reg_addr     (reg_addr),
        .reg_wdata    (reg_wdata),
        .oem_pw_valid (oem_pw_valid),
        .reg_rdata    (reg_rdata),
        .reg_rvalid   (reg_rvalid)
    );

    // the precharge pulse lasts one cycle, so count each one as it passes
    always @(posedge clk) begin
        if (cap_precharge === 1'b1) pre_count <= pre_count + 1;
    end

    // ****************
    // checking helpers
    // ****************
    task automatic chk(input string nm, input logic [11:0] exp, input logic [11:0] got);
        n_tests++;
        if (got !== exp) begin
            $display("MISMATCH %s expected %h seen %h", nm, exp, got);
            fail_count++;
        end
    endtask : chk

    // expect a read to come back, or with ok=0 to be refused
    task automatic rdchk(input logic [7:0] a, input logic ok, input logic [7:0] exp);
        logic [7:0] d;
        logic       got;
        moc_host_model_inst.rd(a, d, got);
        chk("read strobe", {11'h000, ok}, {11'h000, got});
        if (ok && !got) final_report(); // a lost answer is a timeout
        if (ok) chk("read data", {4'h0, exp}, {4'h0, d});
    endtask : rdchk

    task automatic tick(input int n);
        repeat (n) @(negedge clk);
    endtask : tick

    // one raw fault pulse; the latch keeps it afterwards
    task automatic fault_pulse();
        @(negedge clk);
        tx_fault_raw = 1'b1;
        @(negedge clk);
        tx_fault_raw = 1'b0;
        tick(3);
    endtask : fault_pulse

    task automatic do_reset();
        rst_n = 1'b0;
        tick(3);
        rst_n = 1'b1;
    endtask : do_reset

    task automatic final_report();
        if (fail_count == 0 && n_tests > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : final_report

    // ************
    // main sequence
    // ************
    initial begin
        clk = 1'b0; rst_n = 1'b0; tx_fault_raw = 1'b0; transmit_off_input = 1'b0;
        pin7_is_laser_shutdown_output = 1'b1; laser_on = 1'b0; temp_sensed = 8'h11; temp_case = 8'h22;
        fail_count = 0; n_tests = 0;
        @(negedge clk);
        do_reset();
        chk("pw base after reset", 12'h078, {4'h0, pw_base_addr});
        rdchk(8'h1a, 1'b0, 8'h00);
        moc_host_model_inst.wr(8'h1a, 8'hff);
        moc_host_model_inst.set_pw(1'b1);
        rdchk(8'h1a, 1'b1, 8'h00);
        rdchk(8'h1b, 1'b1, 8'h00);
        rdchk(8'h1c, 1'b0, 8'h00);
        moc_host_model_inst.wr(8'h1b, 8'hff);
        rdchk(8'h1b, 1'b1, 8'h1f);
        // start level codes, including the zero code and the top code
        foreach (cfg_vals[i]) begin
            moc_host_model_inst.wr(8'h19, cfg_vals[i]);
            tick(2);
            n_tests++;
            if (laser_start_current_level !== 13'(cfg_vals[i][3:0]) * 13'd375) begin
                $display("MISMATCH start level expected %h seen %h",
                         13'(cfg_vals[i][3:0]) * 13'd375, laser_start_current_level);
                fail_count++;
            end
        end
        moc_host_model_inst.wr(8'h1b, 8'h00);
        // every config five field except shutdown-off in both states through four patterns
        foreach (cfg_vals[i]) begin
            laser_on = i[0];
            moc_host_model_inst.wr(8'h1a, cfg_vals[i]);
            tick(2);
            chk("lut index", cfg_vals[i][6] ? 12'h022 : 12'h011, {4'h0, lut_index_temp});
            chk("temp result", cfg_vals[i][5] ? 12'h022 : 12'h011, {4'h0, temp_result});
            chk("fault idle", {11'h000, cfg_vals[i][4]}, {11'h000, transmit_fault_output});
            chk("multipart", {11'h000, cfg_vals[i][3]}, {11'h000, multipart_mode});
            chk("pw base", cfg_vals[i][2] ? 12'h07b : 12'h078, {4'h0, pw_base_addr});
            chk("timeout en", {11'h000, !cfg_vals[i][1]}, {11'h000, bus_timeout_en});
            chk("dac clear", {11'h000, !i[0] && !cfg_vals[i][0]}, {11'h000, dac_clear});
            rdchk(8'h1a, 1'b1, cfg_vals[i]);
        end
        // latched fault drives shutdown; a transmit-off edge clears it
        moc_host_model_inst.wr(8'h1a, 8'h00);
        pre_base = pre_count;
        fault_pulse();
        chk("fault latched", 12'h001, {11'h000, transmit_fault_output});
        chk("shutdown on", 12'h001, {11'h000, laser_shutdown_output});
        // the pin used for something else never shows shutdown
        pin7_is_laser_shutdown_output = 1'b0;
        tick(2);
        chk("shutdown pin off", 12'h000, {11'h000, laser_shutdown_output});
        pin7_is_laser_shutdown_output = 1'b1;
        tick(2);
        transmit_off_input = ~transmit_off_input;
        tick(4);
        chk("fault cleared", 12'h000, {11'h000, transmit_fault_output});
        chk("precharge", 12'h001, 12'(pre_count - pre_base));
        // shutdown gated off and fault output active low
        moc_host_model_inst.wr(8'h1a, 8'h90);
        fault_pulse();
        chk("fault low", 12'h000, {11'h000, transmit_fault_output});
        chk("shutdown gated", 12'h000, {11'h000, laser_shutdown_output});
        transmit_off_input = ~transmit_off_input;
        tick(4);
        // follow mode tracks the raw fault
        moc_host_model_inst.wr(8'h1a, 8'h00);
        moc_host_model_inst.wr(8'h1b, 8'h01);
        tx_fault_raw = 1'b1;
        tick(3);
        chk("follow high", 12'h001, {11'h000, transmit_fault_output});
        tx_fault_raw = 1'b0;
        tick(3);
        chk("follow low", 12'h000, {11'h000, transmit_fault_output});
        chk("shutdown follows", 12'h000, {11'h000, laser_shutdown_output});
        // a short transmit-off glitch must not clear the latch when filtered
        moc_host_model_inst.wr(8'h1b, 8'h10);
        fault_pulse();
        transmit_off_input = ~transmit_off_input;
        tick(7);
        transmit_off_input = ~transmit_off_input;
        tick(14);
        chk("glitch kept", 12'h001, {11'h000, transmit_fault_output});
        transmit_off_input = ~transmit_off_input;
        tick(14);
        chk("debounced clear", 12'h000, {11'h000, transmit_fault_output});
        // stored bytes outlive a reset
        moc_host_model_inst.wr(8'h1a, 8'ha5);
        do_reset();
        rdchk(8'h1a, 1'b1, 8'ha5);
        rdchk(8'h1b, 1'b1, 8'h10);
        final_report();
    end
endmodule : tb
